// file: sfpse_core.sv
// Purpose: Status, write latch, block protect, power-down and erase command logic of a serial flash
// Assumes: Link pins are asynchronous and sampled by clk; SCK period well above 8 clk cycles
// Notes:   Array erase itself happens outside; this block issues the request and times busy
`timescale 1ns/100ps
`default_nettype none

module sfpse_core
    import sfpse_pkg::*;
#(
    parameter int          SSE_CYCLES = SSE_CYCLES_DEF,
    parameter int          SE_CYCLES  = SE_CYCLES_DEF,
    parameter int          CE_CYCLES  = CE_CYCLES_DEF,
    parameter int          SRW_CYCLES = SRW_CYCLES_DEF,
    parameter logic [7:0]  NV_INIT    = NV_RESET
) (
    // Clock, reset, enable
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    // Link pins
    input  wire logic       sck,
    input  wire logic       cs_b,
    input  wire logic       si,
    input  wire logic       wp_b,
    output logic            so,
    output logic            soOe,
    // Erase request to the array
    output logic            eraseReq,
    output logic [1:0]      eraseKind,
    output logic [6:0]      eraseRegion,
    // Observed state
    output logic [7:0]      statusByte,
    output logic            powerDown
);

    // Pin synchronisers: pinA feeds only pinB
    logic [3:0] pinA;
    logic [3:0] pinB;
    logic [3:0] pinPrev;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pinA    <= 4'h4;
            pinB    <= 4'h4;
            pinPrev <= 4'h4;
        end else if (ce) begin
            pinA    <= {wp_b, cs_b, sck, si};
            pinB    <= pinA;
            pinPrev <= pinB;
        end
    end

    logic siS;
    logic sckRise;
    logic sckFall;
    logic csS;
    logic csRise;
    logic wpS;
    assign siS     = pinB[0];
    assign sckRise = pinB[1] & ~pinPrev[1];
    assign sckFall = ~pinB[1] & pinPrev[1];
    assign csS     = pinB[2];
    assign csRise  = pinB[2] & ~pinPrev[2];
    assign wpS     = pinB[3];

    // Sector overlap with the protected area; granularity is 64 KB
    function automatic logic sectProt(input logic [2:0] sec, input sfpse_status_t s);
        logic p;
        p = 1'b0;
        unique case (s.level)
            3'h0: p = 1'b0;
            3'h1: p = (sec == 3'h7);
            3'h2: p = (sec >= 3'h6);
            3'h3: p = (sec >= 3'h4);
            3'h5: p = s.side ? (sec == 3'h0) : 1'b1;
            3'h6: p = s.side ? (sec <= 3'h1) : 1'b1;
            3'h7: p = s.side ? (sec <= 3'h3) : 1'b1;
            3'h4: p = 1'b1;
        endcase
        return p;
    endfunction

    // Command state
    sfpse_status_t stat;
    sfpse_status_t next_stat;
    sfpse_op_t     op;
    sfpse_op_t     next_op;
    logic [7:0]    shReg;
    logic [7:0]    next_shReg;
    logic [2:0]    bitCnt;
    logic [2:0]    next_bitCnt;
    logic [2:0]    byteCnt;
    logic [2:0]    next_byteCnt;
    logic [7:0]    opcode;
    logic [7:0]    next_opcode;
    logic [7:0]    dataByte;
    logic [7:0]    next_dataByte;
    logic [6:0]    region;
    logic [6:0]    next_region;
    logic          reading;
    logic          next_reading;
    logic [2:0]    outIdx;
    logic [2:0]    next_outIdx;
    logic [31:0]   timer;
    logic [31:0]   next_timer;
    logic          next_so;
    logic          next_soOe;
    logic          next_eraseReq;
    logic [1:0]    next_eraseKind;
    logic [6:0]    next_eraseRegion;
    logic          next_powerDown;

    logic [7:0]    inByte;
    logic          aligned;
    logic          canWrite;
    logic          srwBlocked;
    assign inByte     = {shReg[6:0], siS};
    assign aligned    = (bitCnt == 3'h0);
    assign canWrite   = stat.wen & ~stat.busy & ~powerDown;
    assign srwBlocked = stat.lock & ~wpS;

    // Next-state: framing, command decode, status shifting and busy timer
    always_comb begin
        next_stat        = stat;
        next_op          = op;
        next_shReg       = shReg;
        next_bitCnt      = bitCnt;
        next_byteCnt     = byteCnt;
        next_opcode      = opcode;
        next_dataByte    = dataByte;
        next_region      = region;
        next_reading     = reading;
        next_outIdx      = outIdx;
        next_timer       = timer;
        next_so          = so;
        next_eraseReq    = 1'b0;
        next_eraseKind   = eraseKind;
        next_eraseRegion = eraseRegion;
        next_powerDown   = powerDown;

        // Internal timer; write latch clears on completion or on a write disable command
        if (stat.busy) begin
            if (timer <= 32'h1) begin
                next_stat.busy = 1'b0;
                next_stat.wen  = 1'b0;
                next_op        = OP_IDLE;
                if (op == OP_STATUS) begin
                    next_stat.level = dataByte[4:2];
                    next_stat.side  = dataByte[5];
                    next_stat.lock  = dataByte[7];
                end
            end else begin
                next_timer = timer - 32'h1;
            end
        end

        if (csRise) begin
            // Frame end: decide, then clear framing; misaligned frames do nothing
            next_bitCnt  = 3'h0;
            next_byteCnt = 3'h0;
            next_reading = 1'b0;
            if (aligned && canWrite) begin
                if (opcode == OPC_STATUS_WRITE && byteCnt == LEN_STATUS_WRITE && !srwBlocked) begin
                    next_stat.busy = 1'b1;
                    next_op        = OP_STATUS;
                    next_timer     = 32'(SRW_CYCLES);
                end else if ((opcode == OPC_SSE_A || opcode == OPC_SSE_B) && byteCnt == LEN_ADDR_CMD
                             && !sectProt(region[6:4], stat)) begin
                    next_stat.busy   = 1'b1;
                    next_op          = OP_ERASE;
                    next_timer       = 32'(SSE_CYCLES);
                    next_eraseReq    = 1'b1;
                    next_eraseKind   = ERASE_SMALL;
                    next_eraseRegion = region;
                end else if (opcode == OPC_SE && byteCnt == LEN_ADDR_CMD && !sectProt(region[6:4], stat)) begin
                    next_stat.busy   = 1'b1;
                    next_op          = OP_ERASE;
                    next_timer       = 32'(SE_CYCLES);
                    next_eraseReq    = 1'b1;
                    next_eraseKind   = ERASE_SECT;
                    next_eraseRegion = {region[6:4], 4'h0};
                end else if ((opcode == OPC_CE_A || opcode == OPC_CE_B) && byteCnt == LEN_ONE_BYTE
                             && stat.level == 3'h0) begin
                    next_stat.busy   = 1'b1;
                    next_op          = OP_ERASE;
                    next_timer       = 32'(CE_CYCLES);
                    next_eraseReq    = 1'b1;
                    next_eraseKind   = ERASE_CHIP;
                    next_eraseRegion = 7'h00;
                end
            end
            // Latch and power-down commands; all refused while busy
            if (aligned && byteCnt == LEN_ONE_BYTE && !stat.busy && !powerDown) begin
                if (opcode == OPC_WRITE_ENABLE) begin
                    next_stat.wen = 1'b1;
                end else if (opcode == OPC_WRITE_DISABL) begin
                    next_stat.wen = 1'b0;
                end else if (opcode == OPC_POWER_DOWN) begin
                    next_powerDown = 1'b1;
                end
            end
        end else if (!csS) begin
            // Sample on rising SCK
            if (sckRise) begin
                next_shReg  = inByte;
                next_bitCnt = bitCnt + 3'h1;
                if (bitCnt == 3'h7) begin
                    if (byteCnt != 3'h7) begin
                        next_byteCnt = byteCnt + 3'h1;
                    end
                    if (byteCnt == 3'h0) begin
                        next_opcode = inByte;
                        if (inByte == OPC_STATUS_READ && !powerDown) begin
                            next_reading = 1'b1;
                            next_outIdx  = OUT_IDX_MSB;
                        end
                        if (inByte == OPC_PD_EXIT) begin
                            next_powerDown = 1'b0;
                        end
                    end else if (byteCnt == 3'h1) begin
                        next_dataByte = inByte;
                    end
                    // Second byte carries A23:16, third A15:8; the rest is don't care
                    if (byteCnt == 3'h1) begin
                        next_region[6:4] = inByte[2:0];         // Address bits 18:16
                    end else if (byteCnt == 3'h2) begin
                        next_region[3:0] = inByte[7:4];         // Address bits 15:12
                    end
                end
            end
            // Drive on falling SCK; 3-bit index wraps 0 back to 7
            if (sckFall && reading) begin
                next_so     = statusByte[outIdx];
                next_outIdx = outIdx - 3'h1;
            end
        end
        next_stat.rsvd = 1'b0;
        next_soOe      = next_reading;
    end

    // State registers; the write latch starts cleared
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stat        <= sfpse_status_t'(NV_INIT & 8'hbc);
            op          <= OP_IDLE;
            shReg       <= 8'h00;
            bitCnt      <= 3'h0;
            byteCnt     <= 3'h0;
            opcode      <= 8'h00;
            dataByte    <= 8'h00;
            region      <= 7'h00;
            reading     <= 1'b0;
            outIdx      <= OUT_IDX_MSB;
            timer       <= 32'h0;
            so          <= 1'b0;
            soOe        <= 1'b0;
            eraseReq    <= 1'b0;
            eraseKind   <= 2'h0;
            eraseRegion <= 7'h00;
            powerDown   <= 1'b0;
        end else if (ce) begin
            stat        <= next_stat;
            op          <= next_op;
            shReg       <= next_shReg;
            bitCnt      <= next_bitCnt;
            byteCnt     <= next_byteCnt;
            opcode      <= next_opcode;
            dataByte    <= next_dataByte;
            region      <= next_region;
            reading     <= next_reading;
            outIdx      <= next_outIdx;
            timer       <= next_timer;
            so          <= next_so;
            soOe        <= next_soOe;
            eraseReq    <= next_eraseReq;
            eraseKind   <= next_eraseKind;
            eraseRegion <= next_eraseRegion;
            powerDown   <= next_powerDown;
        end
    end

    assign statusByte = stat;

    // Checks on the command logic
    sequence s_busyStart;
        ce && !stat.busy ##1 stat.busy;
    endsequence

    sequence s_srwReq;
        ce && csRise && aligned && opcode == OPC_STATUS_WRITE && byteCnt == LEN_STATUS_WRITE;
    endsequence

    property p_rsvdZero;
        @(posedge clk) disable iff (!rst_b) statusByte[6] == 1'b0;
    endproperty
    a_rsvdZero: assert property (p_rsvdZero) else $error("reserved status bit set");

    property p_startNeedsWen;
        @(posedge clk) disable iff (!rst_b) s_busyStart |-> $past(stat.wen, 1);
    endproperty
    a_startNeedsWen: assert property (p_startNeedsWen) else $error("write began without latch");

    property p_doneClearsWen;
        @(posedge clk) disable iff (!rst_b) ce && stat.busy ##1 !stat.busy |-> !stat.wen;
    endproperty
    a_doneClearsWen: assert property (p_doneClearsWen) else $error("latch left set after write");

    property p_lockedSrw;
        @(posedge clk) disable iff (!rst_b) s_srwReq and (stat.lock && !wpS) |=> !stat.busy;
    endproperty
    a_lockedSrw: assert property (p_lockedSrw) else $error("locked status write ran");

    property p_wpHighSrw;
        @(posedge clk) disable iff (!rst_b) s_srwReq and (wpS && canWrite) |=> stat.busy && op == OP_STATUS;
    endproperty
    a_wpHighSrw: assert property (p_wpHighSrw) else $error("unprotected status write refused");

    property p_chipLevel;
        @(posedge clk) disable iff (!rst_b) eraseReq && eraseKind == ERASE_CHIP |-> $past(stat.level) == 3'h0;
    endproperty
    a_chipLevel: assert property (p_chipLevel) else $error("chip erase with protection");

    property p_misaligned;
        @(posedge clk) disable iff (!rst_b) ce && csRise && !aligned |=> $stable(stat.wen) && !eraseReq;
    endproperty
    a_misaligned: assert property (p_misaligned) else $error("misaligned frame acted");

    property p_eraseHolds;
        @(posedge clk) disable iff (!rst_b) eraseReq |-> stat.busy [*8];
    endproperty
    a_eraseHolds: assert property (p_eraseHolds) else $error("erase busy ended at once");

    property p_pdWhileBusy;
        @(posedge clk) disable iff (!rst_b) stat.busy && !powerDown |=> !powerDown;
    endproperty
    a_pdWhileBusy: assert property (p_pdWhileBusy) else $error("power-down entered while busy");

    property p_soWrap;
        @(posedge clk) disable iff (!rst_b) ce && sckFall && reading && !csS && outIdx == 3'h0 |=> outIdx == 3'h7;
    endproperty
    a_soWrap: assert property (p_soWrap) else $error("status output did not wrap");

endmodule

`default_nettype wire

// file: sfpse_pkg.sv
// Purpose: Shared constants and types for the serial flash status, protect and erase logic
// Assumes: 250 MHz system clock, link pins sampled by that clock
// Notes:   Times are typical figures; counts are derived from them
package sfpse_pkg;

    // Command opcodes
    localparam logic [7:0] OPC_STATUS_READ  = 8'h05;
    localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OPC_WRITE_DISABL = 8'h04;
    localparam logic [7:0] OPC_POWER_DOWN   = 8'hb9;
    localparam logic [7:0] OPC_PD_EXIT      = 8'hab;
    localparam logic [7:0] OPC_SSE_A        = 8'h20;
    localparam logic [7:0] OPC_SSE_B        = 8'hd7;
    localparam logic [7:0] OPC_SE           = 8'hd8;
    localparam logic [7:0] OPC_CE_A         = 8'h60;
    localparam logic [7:0] OPC_CE_B         = 8'hc7;

    // Frame lengths in bytes
    localparam logic [2:0] LEN_ONE_BYTE     = 3'h1;
    localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
    localparam logic [2:0] LEN_ADDR_CMD     = 3'h4;

    // Erase kinds reported on the erase port
    localparam logic [1:0] ERASE_SMALL = 2'h1;
    localparam logic [1:0] ERASE_SECT  = 2'h2;
    localparam logic [1:0] ERASE_CHIP  = 2'h3;

    // Reset values
    localparam logic [7:0] NV_RESET    = 8'h00;
    localparam logic [2:0] OUT_IDX_MSB = 3'h7;

    // Timing
    localparam int CLK_MHZ        = 250;
    localparam int SSE_TIME_MS    = 40;
    localparam int SE_TIME_MS     = 80;
    localparam int CE_TIME_MS     = 300;
    localparam int SRW_TIME_MS    = 10;
    localparam int SSE_CYCLES_DEF = SSE_TIME_MS * 1000 * CLK_MHZ;
    localparam int SE_CYCLES_DEF  = SE_TIME_MS * 1000 * CLK_MHZ;
    localparam int CE_CYCLES_DEF  = CE_TIME_MS * 1000 * CLK_MHZ;
    localparam int SRW_CYCLES_DEF = SRW_TIME_MS * 1000 * CLK_MHZ;

    // Status byte, bit 7 first
    typedef struct packed {
        logic       lock;
        logic       rsvd;
        logic       side;
        logic [2:0] level;
        logic       wen;
        logic       busy;
    } sfpse_status_t;

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_STATUS,
        OP_ERASE
    } sfpse_op_t;

endpackage

// file: sfpse_spi_host.sv
// Purpose: Model of the link host that frames commands and reads the status byte back
// Assumes: Mode 0, pins change only at clk rising edges, sck period averages 125 ns
// Notes:   sck stands low between frames; si shows the inverse of its last bit once released
`timescale 1ns/100ps
`default_nettype none

module sfpse_spi_host (
    // System clock
    input  wire logic clk,
    // Device outputs
    input  wire logic so,
    input  wire logic soOe,
    // Link pins
    output var logic  sck,
    output var logic  cs_b,
    output var logic  si
);
    // Idle pins before the first frame
    initial begin
        sck  = 1'b0;
        cs_b = 1'b1;
        si   = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One frame of n bits taken from the top of d; so captured from the ninth bit on
    task automatic xfer(input logic [31:0] d, input logic [5:0] n, output logic [15:0] rd, output logic oe);
        int i;
        rd = 16'h0000;
        oe = 1'b0;
        @(posedge clk);
        cs_b <= 1'b0;
        tick(8);
        for (i = 0; i < n; i++) begin
            sck <= 1'b0;
            si  <= d[31-i];
            tick(15);
            // Sample well after the fall so the 3 clk pin delay has settled
            if (i >= 8) begin
                rd = {rd[14:0], so};
                oe = oe | soOe;
            end
            sck <= 1'b1;
            // One extra clk every fourth bit keeps the average period at 125 ns
            tick(16 + ((i % 4 == 3) ? 1 : 0));
        end
        sck <= 1'b0;
        tick(15);
        cs_b <= 1'b1;
        si   <= ~d[32-n];
        // Deselect gap, also lets command effects land
        tick(8);
    endtask
endmodule

`default_nettype wire

// file: sfpse_core_bench.sv
// Purpose: Self-checking bench for the status, protect and erase command logic
// Assumes: Host model drives the link; busy counts shortened, sector erase kept long
// Notes:   Long sector erase leaves room for a status read while busy
`timescale 1ns/100ps
`default_nettype none

module sfpse_core_bench
    import sfpse_pkg::*;
;
    typedef struct packed {
        logic        wp;
        logic [31:0] d;
        logic [5:0]  n;
        logic [7:0]  st;
        logic        pd;
        logic        req;
        logic [1:0]  kind;
        logic [6:0]  rgn;
    } sfpse_row_t;

    // Write enable frame, sent to set the latch before a write
    localparam logic [31:0] WE = {OPC_WRITE_ENABLE, 24'h000000};
    localparam logic [31:0] SW = {OPC_STATUS_WRITE, 24'h000000};
    localparam int          NROW = 34;
    // Frame, then status, power-down and erase request expected once idle
    localparam sfpse_row_t ROWS [NROW] = '{
        '{1'b1, WE, 6'h08, 8'h02, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, {OPC_WRITE_DISABL, 24'h0}, 6'h08, 8'h00, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, {OPC_SSE_A, 24'h0a5000}, 6'h20, 8'h00, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, WE, 6'h08, 8'h02, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, {OPC_SSE_A, 24'h0a5000}, 6'h20, 8'h00, 1'b0, 1'b1, ERASE_SMALL, 7'h25},
        '{1'b1, WE, 6'h08, 8'h02, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, {OPC_SSE_B, 24'h001000}, 6'h20, 8'h00, 1'b0, 1'b1, ERASE_SMALL, 7'h01},
        '{1'b1, WE, 6'h08, 8'h02, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, {OPC_SE, 24'h7b0000}, 6'h20, 8'h00, 1'b0, 1'b1, ERASE_SECT, 7'h30},
        '{1'b1, WE, 6'h08, 8'h02, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, {OPC_CE_A, 24'h0}, 6'h08, 8'h00, 1'b0, 1'b1, ERASE_CHIP, 7'h00},
        '{1'b1, WE, 6'h08, 8'h02, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, {OPC_CE_B, 24'h0}, 6'h08, 8'h00, 1'b0, 1'b1, ERASE_CHIP, 7'h00},
        '{1'b1, WE, 6'h08, 8'h02, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, {OPC_SE, 24'h000000}, 6'h1f, 8'h02, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, SW | 32'h00ff0000, 6'h18, 8'h02, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, SW | 32'h00ff0000, 6'h10, 8'hbc, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b0, WE, 6'h08, 8'hbe, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b0, SW, 6'h10, 8'hbe, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, SW | 32'h00040000, 6'h10, 8'h04, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, WE, 6'h08, 8'h06, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, {OPC_SE, 24'h070000}, 6'h20, 8'h06, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, {OPC_CE_A, 24'h0}, 6'h08, 8'h06, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, {OPC_SE, 24'h060000}, 6'h20, 8'h04, 1'b0, 1'b1, ERASE_SECT, 7'h60},
        '{1'b1, WE, 6'h08, 8'h06, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, SW | 32'h00340000, 6'h10, 8'h34, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, WE, 6'h08, 8'h36, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, {OPC_SE, 24'h000000}, 6'h20, 8'h36, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, {OPC_SE, 24'h010000}, 6'h20, 8'h34, 1'b0, 1'b1, ERASE_SECT, 7'h10},
        '{1'b1, WE, 6'h08, 8'h36, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, SW, 6'h10, 8'h00, 1'b0, 1'b0, 2'h0, 7'h00},
        '{1'b1, {OPC_POWER_DOWN, 24'h0}, 6'h08, 8'h00, 1'b1, 1'b0, 2'h0, 7'h00},
        '{1'b1, WE, 6'h08, 8'h00, 1'b1, 1'b0, 2'h0, 7'h00},
        '{1'b1, {OPC_PD_EXIT, 24'h0}, 6'h08, 8'h00, 1'b0, 1'b0, 2'h0, 7'h00}
    };

    // Design pins
    logic        clk;
    logic        rst_b;
    logic        wp_b;
    wire logic   sck;
    wire logic   cs_b;
    wire logic   si;
    logic        so;
    logic        soOe;
    logic        eraseReq;
    logic [1:0]  eraseKind;
    logic [6:0]  eraseRegion;
    logic [7:0]  statusByte;
    logic        powerDown;
    // Bench bookkeeping
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          cycleCount = 0;
    logic [7:0]  reqCount = 8'h00;
    logic [7:0]  reqBase;
    logic [15:0] rd;
    logic        oe;
    sfpse_row_t  r;

    sfpse_core #(.SSE_CYCLES(40), .SE_CYCLES(3000), .CE_CYCLES(50), .SRW_CYCLES(60)) dut (
        .clk(clk), .rst_b(rst_b), .ce(1'b1), .sck(sck), .cs_b(cs_b), .si(si), .wp_b(wp_b),
        .so(so), .soOe(soOe), .eraseReq(eraseReq), .eraseKind(eraseKind), .eraseRegion(eraseRegion),
        .statusByte(statusByte), .powerDown(powerDown)
    );

    sfpse_spi_host host (.clk(clk), .so(so), .soOe(soOe), .sck(sck), .cs_b(cs_b), .si(si));

    initial clk = 1'b0;
    always #2 clk = ~clk;

    // Count erase pulses; a one-cycle pulse would be missed by polling
    always @(posedge clk) begin
        if (eraseReq === 1'b1) begin
            reqCount <= reqCount + 8'h01;
        end
    end

    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cycleCount++;
        if (cycleCount == 60000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait for busy to clear
    task automatic waitIdle();
        int k;
        for (k = 0; k < 4000 && statusByte[0] !== 1'b0; k++) begin
            @(posedge clk);
        end
        repeat (2) @(posedge clk);
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence: reset, table, then the awkward cases
    initial begin
        rst_b = 1'b0;
        wp_b  = 1'b1;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        check({statusByte, 4'h0, powerDown, soOe, so, eraseReq}, 16'h0000);
        for (int i = 0; i < NROW; i++) begin
            r = ROWS[i];
            @(posedge clk);
            wp_b <= r.wp;
            reqBase = reqCount;
            host.xfer(r.d, r.n, rd, oe);
            waitIdle();
            check({8'h00, statusByte}, {8'h00, r.st});
            check({15'h0000, powerDown}, {15'h0000, r.pd});
            check({8'h00, reqCount - reqBase}, {15'h0000, r.req});
            if (r.req) begin
                check({7'h00, eraseKind, eraseRegion}, {7'h00, r.kind, r.rgn});
            end
        end
        // Status byte MSB first, then repeated
        host.xfer(WE, 6'h08, rd, oe);
        host.xfer({OPC_STATUS_READ, 24'h0}, 6'h18, rd, oe);
        check(rd, 16'h0202);
        check({15'h0000, oe}, 16'h0001);
        // Read and power-down request in the middle of a long erase
        host.xfer({OPC_SE, 24'h000000}, 6'h20, rd, oe);
        host.xfer({OPC_STATUS_READ, 24'h0}, 6'h18, rd, oe);
        check(rd, 16'h0303);
        host.xfer({OPC_POWER_DOWN, 24'h0}, 6'h08, rd, oe);
        check({15'h0000, powerDown}, 16'h0000);
        waitIdle();
        check({8'h00, statusByte}, 16'h0000);
        // Write latch lost across a reset in mid-run
        host.xfer(WE, 6'h08, rd, oe);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        check({8'h00, statusByte}, 16'h0000);
        results();
    end
endmodule

`default_nettype wire
